// >>> pkg/clcc_pkg.sv
// Purpose: Shared constants and types for the command-list, glyph-cache and pixel-clock interpreter.
// Assumes: 32-bit command words, APB register access, one 250 MHz clock.
// Notes:   Format codes and the pointer-query opcode are local values.
package clcc_pkg;

	// ****************************************
	// Command opcodes
	// ****************************************
	localparam logic [31:0] OP_START_LIST = 32'hffffff68;
	localparam logic [31:0] OP_END_LIST = 32'hffffff69;
	localparam logic [31:0] OP_CALL_LIST = 32'hffffff67;
	localparam logic [31:0] OP_RETURN = 32'hffffff66;
	localparam logic [31:0] OP_GLYPH_CACHE = 32'hffffff6b;
	localparam logic [31:0] OP_CACHE_QUERY = 32'hffffff6c;
	localparam logic [31:0] OP_IMAGE_ATTR = 32'hffffff64;
	localparam logic [31:0] OP_HSCALE = 32'hffffff62;
	localparam logic [31:0] OP_PCLK_REQ = 32'hffffff6a;
	localparam logic [31:0] OP_PTR_QUERY = 32'hffffff23;

	// Parameter word counts, output slots included
	localparam logic [2:0] NPAR_ONE = 3'h1;
	localparam logic [2:0] NPAR_CACHE = 3'h3;
	localparam logic [2:0] NPAR_QUERY = 3'h2;
	localparam logic [2:0] NPAR_IMAGE = 3'h5;
	localparam logic [2:0] NPAR_PCLK = 3'h3;

	// Pixel formats that carry a palette (values are arbitrary)
	localparam logic [31:0] FMT_INDEXED_COLOR_565 = 32'h00000010;
	localparam logic [31:0] FMT_INDEXED_COLOR_4444 = 32'h00000011;

	// ****************************************
	// List memory and call stack
	// ****************************************
	localparam int LIST_AW = 6;
	localparam int LIST_WORDS = 64;
	localparam int STACK_DEPTH = 4;
	localparam logic [2:0] STACK_MAX = 3'h4;
	localparam int NUM_OUT = 5;
	localparam int NUM_PAR = 5;
	localparam int OUT_TOTAL = 0;
	localparam int OUT_USED = 1;
	localparam int OUT_FACTUAL = 2;

	// ****************************************
	// Pixel-clock search
	// ****************************************
	localparam logic [31:0] PCLK_STEP_HZ = 32'd1000000;
	localparam logic [7:0] PCLK_KMAX = 8'h7f;
	localparam logic [31:0] RND_NEAREST = 32'h00000000;
	localparam logic [31:0] RND_DOWN = 32'hffffffff;
	localparam logic [31:0] RND_UP = 32'h00000001;

	// ****************************************
	// APB register map (byte addresses)
	// ****************************************
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_OUT0 = 8'h08;
	localparam logic [7:0] REG_OUT4 = 8'h18;
	localparam logic [7:0] REG_PCLK = 8'h1c;
	localparam logic [7:0] REG_HSF = 8'h20;
	localparam int ST_BUSY = 0;
	localparam int ST_COMPILE = 1;
	localparam int ST_FAULT = 2;
	localparam int ST_DEPTH = 4;

	typedef enum logic [0:0] {S_READY, S_PCLK} clcc_state_t;

endpackage

// >>> core/clcc_pclk_search.sv
// Purpose: Walks every achievable pixel clock and keeps the best one for the rounding mode.
// Assumes: Achievable clocks are k * PCLK_STEP_HZ, k = 1..PCLK_KMAX.
// Notes:   One candidate per cycle; o_done pulses after PCLK_KMAX cycles.
`timescale 1ns/10ps
module clcc_pclk_search (
	input wire logic i_clock,          // 250 MHz clock
	input wire logic i_rst_n,          // Async reset, active low
	input wire logic i_clk_en,         // Freezes state while low
	input wire logic i_start,          // Start pulse
	input wire logic [31:0] i_target,  // Target frequency, Hz
	input wire logic [31:0] i_round,   // Rounding mode
	output logic o_done,               // Result valid pulse
	output logic o_found,              // A suitable frequency exists
	output logic [7:0] o_setting,      // Multiplier to program
	output logic [31:0] o_freq         // Frequency achieved
);
	import clcc_pkg::*;

	typedef struct packed {
		logic busy;
		logic done;
		logic found;
		logic [7:0] k;
		logic [31:0] acc;
		logic [31:0] target;
		logic [31:0] round;
		logic [7:0] best_k;
		logic [31:0] best_f;
		logic [31:0] best_err;
	} clcc_search_t;

	clcc_search_t s, next_s;
	logic [31:0] err;
	logic take;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		err = (s.acc > s.target) ? (s.acc - s.target) : (s.target - s.acc);
		take = 1'b0;
		if (!s.busy && i_start) begin
			next_s.busy = 1'b1;
			next_s.k = 8'h01;
			next_s.acc = PCLK_STEP_HZ;
			next_s.found = 1'b0;
			next_s.target = i_target;
			next_s.round = i_round;
		end else if (s.busy) begin
			unique case (s.round)
				RND_NEAREST: take = !s.found || (err < s.best_err);
				RND_DOWN: take = (s.acc <= s.target);
				RND_UP: take = !s.found && (s.acc >= s.target);
				default: take = 1'b0;
			endcase
			if (take) begin
				next_s.found = 1'b1;
				next_s.best_k = s.k;
				next_s.best_f = s.acc;
				next_s.best_err = err;
			end
			if (s.k == PCLK_KMAX) begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end else begin
				next_s.k = s.k + 8'h01;
				next_s.acc = s.acc + PCLK_STEP_HZ;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s <= '0;
		end else if (i_clk_en) begin
			s <= next_s;
		end
	end

	assign o_done = s.done;
	assign o_found = s.found;
	assign o_setting = s.best_k;
	assign o_freq = s.best_f;

endmodule

// >>> core/clcc_interp.sv
// Purpose: Command interpreter for list compile/call/return, glyph cache, image query, scaling, pixel clock.
// Assumes: Host pushes command words through the APB command register; lists live in local memory.
// Notes:   List addresses wrap onto LIST_WORDS words; the stream stalls (pready low) while a list runs.
`timescale 1ns/10ps
module clcc_interp (
	input wire logic i_clock,                 // 250 MHz clock
	input wire logic i_rst_n,                 // Async reset, active low
	input wire logic i_clk_en,                // Freezes all state while low
	input wire logic i_psel,                  // APB select
	input wire logic i_penable,               // APB enable
	input wire logic i_pwrite,                // APB direction
	input wire logic [7:0] i_paddr,           // APB byte address
	input wire logic [31:0] i_pwdata,         // APB write data
	output logic [31:0] o_prdata,             // APB read data
	output logic o_pready,                    // APB ready
	output logic o_pslverr,                   // APB error on unmapped address
	input wire logic i_img_done,              // Image decoder finished, pulse
	input wire logic [31:0] i_img_source,     // Decoded bitmap address
	input wire logic [31:0] i_img_format,     // Decoded bitmap format
	input wire logic [31:0] i_img_width,      // Decoded width
	input wire logic [31:0] i_img_height,     // Decoded height
	input wire logic [31:0] i_img_palette,    // Decoded palette address
	input wire logic [31:0] i_cache_used,     // Glyph cache bytes in use
	input wire logic [15:0] i_hsize,          // Horizontal render size
	output logic o_cache_enable,              // Glyph cache active
	output logic [31:0] o_cache_font,         // Cached font handle
	output logic [31:0] o_cache_base,         // Cache area start
	output logic [31:0] o_cache_size,         // Cache area size, bytes
	output logic o_hsf_enable,                // Horizontal scaling active
	output logic [31:0] o_hsf_width,          // Output pixel width
	output logic [7:0] o_pixel_clock_freq_setting // Pixel clock setting
);
	import clcc_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		clcc_state_t st;
		logic compiling;
		logic [LIST_AW-1:0] cptr;
		logic [LIST_AW-1:0] pc;
		logic [2:0] depth;
		logic [STACK_DEPTH-1:0][LIST_AW-1:0] stack;
		logic [LIST_WORDS-1:0][31:0] mem;
		logic [31:0] op;
		logic [2:0] pleft;
		logic [2:0] pidx;
		logic [NUM_PAR-1:0][31:0] par;
		logic [NUM_OUT-1:0][31:0] outf;
		logic [NUM_OUT-1:0][31:0] img;
		logic fault;
		logic cache_en;
		logic [31:0] cache_font;
		logic [31:0] cache_base;
		logic [31:0] cache_size;
		logic hsf_en;
		logic [31:0] hsf_w;
		logic [7:0] pclk_set;
		logic pclk_start;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} clcc_regs_t;

	clcc_regs_t s, next_s;
	logic access;
	logic cmd_wr;
	logic w_valid;
	logic [31:0] w;
	logic exec_now;
	logic [2:0] out_sel;
	logic [31:0] status;
	logic pc_done;
	logic pc_found;
	logic [7:0] pc_setting;
	logic [31:0] pc_freq;

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic logic [2:0] par_count(input logic [31:0] op);
		unique case (op)
			OP_START_LIST, OP_CALL_LIST, OP_HSCALE, OP_PTR_QUERY: par_count = NPAR_ONE;
			OP_GLYPH_CACHE: par_count = NPAR_CACHE;
			OP_CACHE_QUERY: par_count = NPAR_QUERY;
			OP_IMAGE_ATTR: par_count = NPAR_IMAGE;
			OP_PCLK_REQ: par_count = NPAR_PCLK;
			default: par_count = 3'h0;
		endcase
	endfunction

	function automatic logic [LIST_AW-1:0] list_index(input logic [31:0] a);
		list_index = a[LIST_AW+1:2];
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == REG_CMD) || (a == REG_STATUS) || (a == REG_PCLK) || (a == REG_HSF)
			|| ((a >= REG_OUT0) && (a <= REG_OUT4) && (a[1:0] == 2'b00));
	endfunction

	// ****************************************
	// Pixel clock search
	// ****************************************
	clcc_pclk_search u_search (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_start(s.pclk_start),
		.i_target(s.par[0]),
		.i_round(s.par[1]),
		.o_done(pc_done),
		.o_found(pc_found),
		.o_setting(pc_setting),
		.o_freq(pc_freq)
	);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.pready = 1'b0;
		// Error flag stands with ready only, never into the next cycle
		next_s.pslverr = 1'b0;
		next_s.pclk_start = 1'b0;
		access = i_psel && i_penable;
		cmd_wr = i_pwrite && (i_paddr == REG_CMD);
		out_sel = 3'((i_paddr - REG_OUT0) >> 2);
		status = '0;
		status[ST_BUSY] = (s.st != S_READY) || (s.depth != 3'h0);
		status[ST_COMPILE] = s.compiling;
		status[ST_FAULT] = s.fault;
		status[ST_DEPTH+2:ST_DEPTH] = s.depth;
		w_valid = 1'b0;
		w = '0;
		exec_now = 1'b0;

		// APB: a command word waits until the interpreter is free, giving back-pressure
		if (access && !s.pready && (!cmd_wr || !status[ST_BUSY])) begin
			next_s.pready = 1'b1;
			next_s.pslverr = !is_mapped(i_paddr);
			next_s.prdata = '0;
			if (!i_pwrite && is_mapped(i_paddr)) begin
				if (i_paddr == REG_STATUS) begin
					next_s.prdata = status;
				end else if (i_paddr == REG_PCLK) begin
					next_s.prdata = {24'h000000, s.pclk_set};
				end else if (i_paddr == REG_HSF) begin
					next_s.prdata = s.hsf_w;
				end else if (i_paddr != REG_CMD) begin
					next_s.prdata = s.outf[out_sel];
				end
			end
		end
		if (access && s.pready && i_pwrite) begin
			if (i_paddr == REG_CMD) begin
				w_valid = 1'b1;
				w = i_pwdata;
			end else if (i_paddr == REG_STATUS && i_pwdata[ST_FAULT]) begin
				next_s.fault = 1'b0;
			end
		end

		// Inside a called list the words come from list memory, one per cycle
		if (s.st == S_READY && s.depth != 3'h0) begin
			w_valid = 1'b1;
			w = s.mem[s.pc];
			next_s.pc = s.pc + 1'b1;
		end

		// ****************************************
		// Word parsing
		// ****************************************
		if (w_valid) begin
			if (s.pleft == 3'h0) begin
				if (s.compiling && w == OP_END_LIST) begin
					next_s.mem[s.cptr] = OP_RETURN;
					next_s.cptr = s.cptr + 1'b1;
					next_s.compiling = 1'b0;
				end else begin
					next_s.op = w;
					next_s.pleft = par_count(w);
					next_s.pidx = 3'h0;
					if (s.compiling) begin
						next_s.mem[s.cptr] = w;
						next_s.cptr = s.cptr + 1'b1;
					end else if (par_count(w) == 3'h0) begin
						exec_now = 1'b1;
					end
				end
			end else begin
				next_s.pleft = s.pleft - 3'h1;
				next_s.pidx = s.pidx + 3'h1;
				if (s.compiling) begin
					next_s.mem[s.cptr] = w;
					next_s.cptr = s.cptr + 1'b1;
				end else begin
					next_s.par[s.pidx] = w;
					exec_now = (s.pleft == 3'h1);
				end
			end
		end

		// ****************************************
		// Command execution
		// ****************************************
		if (exec_now) begin
			unique case (next_s.op)
				OP_START_LIST: begin
					next_s.compiling = 1'b1;
					next_s.cptr = list_index(next_s.par[0]);
				end
				OP_CALL_LIST: begin
					if (s.depth < STACK_MAX) begin
						next_s.stack[s.depth[1:0]] = next_s.pc;
						next_s.depth = s.depth + 3'h1;
						next_s.pc = list_index(next_s.par[0]);
					end else begin
						next_s.fault = 1'b1;
					end
				end
				OP_RETURN: begin
					if (s.depth != 3'h0) begin
						next_s.depth = s.depth - 3'h1;
						next_s.pc = s.stack[2'(s.depth - 3'h1)];
					end
				end
				OP_GLYPH_CACHE: begin
					next_s.cache_en = 1'b1;
					next_s.cache_font = next_s.par[0];
					next_s.cache_base = next_s.par[1];
					next_s.cache_size = next_s.par[2];
				end
				OP_CACHE_QUERY: begin
					next_s.outf[OUT_TOTAL] = s.cache_en ? s.cache_size : '0;
					next_s.outf[OUT_USED] = s.cache_en ? i_cache_used : '0;
				end
				OP_IMAGE_ATTR: begin
					next_s.outf = s.img;
					if (s.img[1] != FMT_INDEXED_COLOR_565 && s.img[1] != FMT_INDEXED_COLOR_4444) begin
						next_s.outf[4] = '0;
					end
				end
				OP_HSCALE: begin
					if (next_s.par[0] == '0) begin
						next_s.hsf_en = 1'b0;
						next_s.hsf_w = '0;
					end else if (next_s.par[0] < {16'h0000, i_hsize}) begin
						next_s.hsf_en = 1'b1;
						next_s.hsf_w = next_s.par[0];
					end else begin
						next_s.fault = 1'b1;
					end
				end
				OP_PCLK_REQ: begin
					next_s.st = S_PCLK;
					next_s.pclk_start = 1'b1;
				end
				OP_PTR_QUERY: begin
					next_s.outf[0] = {{(30 - LIST_AW){1'b0}}, s.cptr, 2'b00};
				end
				default: begin
				end
			endcase
		end

		// Search finished: keep the old setting when nothing fits
		if (s.st == S_PCLK && pc_done) begin
			next_s.st = S_READY;
			if (pc_found) begin
				next_s.pclk_set = pc_setting;
			end
			next_s.outf[OUT_FACTUAL] = pc_found ? pc_freq : '0;
		end

		if (i_img_done) begin
			next_s.img = {i_img_palette, i_img_height, i_img_width, i_img_format, i_img_source};
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s <= '0;
		end else if (i_clk_en) begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_prdata = s.prdata;
	assign o_pready = s.pready;
	assign o_pslverr = s.pslverr;
	assign o_cache_enable = s.cache_en;
	assign o_cache_font = s.cache_font;
	assign o_cache_base = s.cache_base;
	assign o_cache_size = s.cache_size;
	assign o_hsf_enable = s.hsf_en;
	assign o_hsf_width = s.hsf_w;
	assign o_pixel_clock_freq_setting = s.pclk_set;

endmodule

// >>> sim/clcc_interp_chk.sv
// Purpose: Bus and output relations of the command interpreter.
// Assumes: One clock domain, asynchronous reset active low.
// Notes:   Sees only the top ports and is attached by bind.
`timescale 1ns/10ps
module clcc_interp_chk import clcc_pkg::*; (
	input wire logic i_clock, // Clock
	input wire logic i_rst_n, // Reset, active low
	input wire logic i_psel, // Select
	input wire logic i_penable, // Enable
	input wire logic i_pwrite, // Direction
	input wire logic [7:0] i_paddr, // Address
	input wire logic [31:0] o_prdata, // Read data
	input wire logic o_pready, // Ready
	input wire logic o_pslverr, // Error
	input wire logic [15:0] i_hsize, // Render width
	input wire logic o_cache_enable, // Cache on
	input wire logic o_hsf_enable, // Scaling on
	input wire logic [31:0] o_hsf_width, // Scaled width
	input wire logic [7:0] o_pixel_clock_freq_setting // Clock setting
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// ****************************************
	// Relations
	// ****************************************
	chk_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
		else $error("ready outside an access");
	chk_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
	chk_slverr_zero: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
		else $error("refusal without ready or with data");
	chk_reset_idle: assert property (!$past(i_rst_n) |-> !o_pready && !o_hsf_enable && !o_cache_enable
		&& o_pixel_clock_freq_setting == 8'h0)
		else $error("outputs not idle after reset");
	chk_hsf_zero_off: assert property (o_hsf_enable |-> o_hsf_width != 32'h0)
		else $error("scaling on with zero width");
	chk_hsf_below_size: assert property ($changed(o_hsf_width) && o_hsf_enable
		|-> o_hsf_width < {16'h0, $past(i_hsize)})
		else $error("scaled width not below render width");
	chk_hsf_read: assert property (o_pready && i_psel && !i_pwrite && i_paddr == REG_HSF
		|-> o_prdata == o_hsf_width)
		else $error("scaling read differs from output");
	chk_pclk_range: assert property ($changed(o_pixel_clock_freq_setting)
		|-> o_pixel_clock_freq_setting inside {[8'h1:PCLK_KMAX]})
		else $error("clock setting outside achievable range");
endmodule
bind clcc_interp clcc_interp_chk u_chk (.i_clock, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_prdata,
	.o_pready, .o_pslverr, .i_hsize, .o_cache_enable, .o_hsf_enable, .o_hsf_width, .o_pixel_clock_freq_setting);

// >>> sim/clcc_host.sv
// Purpose: Host controller model feeding command words over APB.
// Assumes: Slave answers with a one-cycle ready pulse.
// Notes:   Each read leaves a note {care, value} for the bench monitor.
`timescale 1ns/10ps
module clcc_host (
	input wire logic i_clock, // Bus clock
	input wire logic i_pready, // Slave ready
	input wire logic [31:0] i_prdata, // Read data
	output logic o_psel, // Select
	output logic o_penable, // Enable
	output logic o_pwrite, // Direction
	output logic [7:0] o_paddr, // Byte address
	output logic [31:0] o_pwdata, // Write data
	output logic o_hung // Slave never answered
);
	logic [32:0] note_q[$];
	logic [31:0] last;
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 8'h0;
		o_pwdata = 32'h0;
		o_hung = 1'b0;
	end
	// ****************************************
	// One transfer, entered just after an edge
	// ****************************************
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic care,
		input logic [31:0] e);
		int n;
		n = 0;
		if (!w) note_q.push_back({care, e});
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_clock);
		o_penable <= 1'b1;
		do begin
			@(posedge i_clock);
			n++;
		end while (i_pready !== 1'b1 && n < 2000);
		if (n >= 2000) o_hung <= 1'b1;
		last = i_prdata;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		// Released lines flip so stale values never look valid
		o_paddr <= ~a;
		o_pwdata <= ~d;
		@(posedge i_clock);
	endtask
endmodule

// >>> sim/test_coproc_list_cache_clock_cmds.sv
// Purpose: Self-checking bench for the command interpreter.
// Assumes: Host model drives APB; bench drives decoder and render inputs.
// Notes:   Reads wait for busy low, then queue their expected value.
`timescale 1ns/10ps
module test_coproc_list_cache_clock_cmds;
	import clcc_pkg::*;
	logic i_clock, i_rst_n, i_clk_en, i_psel, i_penable, i_pwrite, i_img_done, o_pready, o_pslverr, hung;
	logic o_cache_enable, o_hsf_enable;
	logic [7:0] i_paddr, o_pixel_clock_freq_setting, ks;
	logic [15:0] i_hsize;
	logic [31:0] i_pwdata, o_prdata, i_cache_used, o_cache_font, o_cache_base, o_cache_size, o_hsf_width, w;
	logic [31:0] img [5];
	logic [32:0] note;
	logic err_seen;
	logic [31:0] fm [3] = '{FMT_INDEXED_COLOR_565, FMT_INDEXED_COLOR_4444, 32'h2};
	logic [31:0] tg [8] = '{32'd9500000, 32'd9600000, 32'd9600000, 32'd9600000, 32'd200000000, 32'd200000000,
		32'd500000, 32'd9600000};
	logic [31:0] rm [8] = '{RND_NEAREST, RND_NEAREST, RND_DOWN, RND_UP, RND_DOWN, RND_UP, RND_DOWN, 32'h2};
	logic [7:0] kk [8] = '{8'h9, 8'ha, 8'h9, 8'ha, 8'h7f, 8'h0, 8'h0, 8'h0};
	int n_mismatch = 0;
	int check_count = 0;
	clcc_interp u_dut (.i_clock, .i_rst_n, .i_clk_en, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
		.o_pready, .o_pslverr, .i_img_done, .i_img_source(img[0]), .i_img_format(img[1]), .i_img_width(img[2]),
		.i_img_height(img[3]), .i_img_palette(img[4]), .i_cache_used, .i_hsize, .o_cache_enable, .o_cache_font,
		.o_cache_base, .o_cache_size, .o_hsf_enable, .o_hsf_width, .o_pixel_clock_freq_setting);
	clcc_host u_host (.i_clock, .i_pready(o_pready), .i_prdata(o_prdata), .o_psel(i_psel), .o_penable(i_penable),
		.o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata), .o_hung(hung));
	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic results;
		if (n_mismatch == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cw(input logic [31:0] d);
		u_host.xfer(1'b1, REG_CMD, d, 1'b0, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		int n;
		n = 0;
		do begin
			u_host.xfer(1'b0, REG_STATUS, 32'h0, 1'b0, 32'h0);
			n++;
		end while (u_host.last[ST_BUSY] !== 1'b0 && n < 500);
		if (n >= 500) begin
			n_mismatch++;
			results();
		end
		u_host.xfer(1'b0, a, 32'h0, 1'b1, e);
	endtask
	task automatic call_list(input logic [31:0] a, input logic [31:0] t);
		cw(OP_START_LIST);
		cw(a);
		cw(OP_CALL_LIST);
		cw(t);
		cw(OP_END_LIST);
	endtask
	always @(posedge i_clock) begin
		if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1) begin
			note = u_host.note_q.pop_front();
			if (note[32]) cmp(o_prdata, note[31:0]);
		end
		if (i_psel && i_penable && o_pready === 1'b1) begin
			err_seen <= o_pslverr;
		end
	end
	always @(posedge hung) begin
		n_mismatch++;
		results();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(75674));
		i_rst_n = 1'b0;
		i_clk_en = 1'b1;
		i_img_done = 1'b0;
		i_hsize = 16'd800;
		i_cache_used = $urandom;
		ks = 8'h0;
		for (int j = 0; j < 5; j++) img[j] = 32'h0;
		repeat (16) @(posedge i_clock);
		i_rst_n <= 1'b1;
		@(posedge i_clock);
		rd(REG_STATUS, 32'h0);
		rd(REG_PCLK, 32'h0);
		rd(REG_HSF, 32'h0);
		rd(8'h40, 32'h0);
		cmp({31'h0, err_seen}, 32'h1);
		w = 32'd6 + ($urandom % 32'd794);
		cw(OP_START_LIST);
		cw(32'h10);
		rd(REG_STATUS, 32'h2);
		cw(OP_HSCALE);
		cw(w);
		cw(OP_END_LIST);
		rd(REG_HSF, 32'h0);
		cmp({31'h0, err_seen}, 32'h0);
		rd(REG_STATUS, 32'h0);
		cw(OP_PTR_QUERY);
		cw(32'h0);
		rd(REG_OUT0, 32'h1c);
		cw(OP_CALL_LIST);
		cw(32'h10);
		rd(REG_HSF, w);
		cw(OP_START_LIST);
		cw(32'h40);
		cw(OP_CALL_LIST);
		cw(32'h10);
		cw(OP_HSCALE);
		cw(32'd5);
		cw(OP_END_LIST);
		call_list(32'h60, 32'h40);
		call_list(32'h90, 32'h60);
		call_list(32'ha0, 32'h90);
		cw(OP_CALL_LIST);
		cw(32'h90);
		rd(REG_STATUS, 32'h0);
		rd(REG_HSF, 32'd5);
		cmp(o_hsf_width, 32'd5);
		cmp({31'h0, o_hsf_enable}, 32'h1);
		cw(OP_CALL_LIST);
		cw(32'ha0);
		rd(REG_STATUS, 32'h4);
		u_host.xfer(1'b1, REG_STATUS, 32'h4, 1'b0, 32'h0);
		cw(OP_HSCALE);
		cw({16'h0, i_hsize});
		rd(REG_STATUS, 32'h4);
		rd(REG_HSF, 32'd5);
		u_host.xfer(1'b1, REG_STATUS, 32'h4, 1'b0, 32'h0);
		cw(OP_HSCALE);
		cw({16'h0, i_hsize} - 32'h1);
		rd(REG_HSF, {16'h0, i_hsize} - 32'h1);
		cw(OP_HSCALE);
		cw(32'h0);
		rd(REG_HSF, 32'h0);
		cmp({31'h0, o_hsf_enable}, 32'h0);
		cw(OP_CACHE_QUERY);
		cw(32'h0);
		cw(32'h0);
		rd(REG_OUT0, 32'h0);
		cw(OP_GLYPH_CACHE);
		cw(32'hd);
		cw(32'hf0000);
		cw(32'h4000);
		cmp(o_cache_base, 32'hf0000);
		cmp(o_cache_size, 32'h4000);
		cmp(o_cache_font, 32'hd);
		cmp({31'h0, o_cache_enable}, 32'h1);
		cw(OP_CACHE_QUERY);
		cw(32'h0);
		cw(32'h0);
		rd(REG_OUT0, 32'h4000);
		rd(REG_OUT0 + 8'h4, i_cache_used);
		for (int f = 0; f < 3; f++) begin
			for (int j = 0; j < 5; j++) img[j] <= (j == 1) ? fm[f] : $urandom;
			i_img_done <= 1'b1;
			@(posedge i_clock);
			i_img_done <= 1'b0;
			cw(OP_IMAGE_ATTR);
			repeat (5) cw(32'h0);
			for (int j = 0; j < 5; j++) rd(REG_OUT0 + 8'(4 * j), (j == 4 && f == 2) ? 32'h0 : img[j]);
		end
		// Frozen clock enable must drop a decoder pulse, so the old image stays
		w = img[0];
		i_clk_en <= 1'b0;
		img[0] <= ~w;
		i_img_done <= 1'b1;
		@(posedge i_clock);
		i_img_done <= 1'b0;
		@(posedge i_clock);
		i_clk_en <= 1'b1;
		cw(OP_IMAGE_ATTR);
		repeat (5) cw(32'h0);
		rd(REG_OUT0, w);
		// Flash, support data and full speed are taken as ready on the host side
		for (int i = 0; i < 8; i++) begin
			cw(OP_PCLK_REQ);
			cw(tg[i]);
			cw(rm[i]);
			cw(32'h0);
			if (kk[i] != 8'h0) ks = kk[i];
			rd(REG_OUT0 + 8'h8, {24'h0, kk[i]} * PCLK_STEP_HZ);
			rd(REG_PCLK, {24'h0, ks});
			cmp({24'h0, o_pixel_clock_freq_setting}, {24'h0, ks});
		end
		results();
	end
endmodule
